// >>> core/cef_map.svh
/*
  Offsets, bit positions and reset values for the charger event and
  timer-expiry status logic. Assumes inclusion by bare name.
*/
`ifndef CEF_MAP_SVH
`define CEF_MAP_SVH

`define CEF_EVENT_ADDR        8'h04
`define CEF_TIMER_ADDR        8'h02
`define CEF_EVENT_RESET       8'h00
`define CEF_TIMER_RESET       8'h00
`define CEF_RUN_EN_ADDR       8'h19
`define CEF_RUN_EN_BIT        6
`define CEF_VBMIN_ADDR        8'h0C
`define CEF_BIT_SAFETY        0
`define CEF_BIT_WATCHDOG      1
`define CEF_BIT_SRC_FAIL      7
`define CEF_BIT_SEC_IN        6
`define CEF_BIT_PRI_IN        5
`define CEF_BIT_LOWV          4
`define CEF_BIT_DONE          3
`define CEF_BIT_PHASE         2
`define CEF_BIT_WEAK          1
`define CEF_BIT_CELL          0
`define CEF_WATCHDOG_SEC      100

`endif

// >>> core/cef_pkg.sv
/*
  Types shared by the charger event flag logic.
  Assumes cef_map.svh is on the include path.
*/
`default_nettype none

package cef_pkg;
  // Raw conditions from the analog and timer side, one cycle pulses or levels
  typedef struct packed {
    logic       source_check_failed;
    logic       sec_present;
    logic       pri_present;
    logic       charging;
    logic       charge_start;
    logic       cell_above_lowv;
    logic       charge_done;
    logic       fast_charge;
    logic [2:0] cell_level;
    logic       cell_absent_status;
    logic       watchdog_timeout;
    logic       safety_timeout;
  } cef_cond_t;

  // Register access port
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cef_req_t;
endpackage

`default_nettype wire

// >>> core/cef_flags.sv
/*
  Charger event register (read-clear) and timer-expiry status bits.
  Assumes conditions arrive from logic on sys_clk; register access comes
  from the I2C slave on the same clock as one-cycle rd/wr strobes.
*/
// How it works
// [R1] Watchdog timeout in charge mode sets read-only watchdog expired bit.
// [R2] Watchdog expiry restores register defaults and clears watchdog run enable.
// [R3] Writing run enable one, or input reinsertion, clears watchdog expired bit.
// [R4] Safety timer expiry sets status bit zero.
// [R5] Event register at 04h, eight read-clear flags, reset zero.
// [R6] Bit 7 sets when either input fails validation.
// [R7] Bit 6 sets on secondary input plug in or plug out.
// [R8] Bit 5 sets on primary input plug in or plug out.
// [R9] Bit 4 sets on low threshold crossing, charge start above, plug out above.
// [R10] Bit 3 sets when charge ends on termination with termination enabled.
// [R11] Bit 2 sets on any pre-charge and fast charge phase change.
// [R12] Bit 1 sets when cell is below programmed minimum at plug in.
// [R13] Bit 0 sets when cell presence determination changes.
// [R14] Flags hold until read; read clears them; concurrent events survive.
`timescale 1ns/1ns
`default_nettype none
`include "cef_map.svh"

module cef_flags (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire cef_pkg::cef_cond_t cond,
  input  wire cef_pkg::cef_req_t  req,
  input  wire logic             termination_enable,
  output logic [7:0]            rdata,
  output logic                  watchdog_run_enable,
  output logic [2:0]            cell_min_threshold,
  output logic                  regs_to_default
);
  import cef_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Host strobe decode and watchdog trip
  logic       event_read;
  logic       run_en_write;
  logic       run_en_set;
  logic       vbmin_write;
  logic       wd_trip;

  always_comb begin
    event_read   = req.rd && (req.addr == `CEF_EVENT_ADDR);
    run_en_write = req.wr && (req.addr == `CEF_RUN_EN_ADDR);
    run_en_set   = run_en_write && req.wdata[`CEF_RUN_EN_BIT];
    vbmin_write  = req.wr && (req.addr == `CEF_VBMIN_ADDR);
    // The timer itself lives outside; an expiry outside charge mode is not reported here
    wd_trip      = cond.watchdog_timeout && cond.charging;              // [R1]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition history for edge detection
  // History resets low, so an input already present at release reads as a plug in
  logic       sec_q;
  logic       pri_q;
  logic       fast_q;
  logic       absent_q;
  logic       lowv_q;
  logic       next_sec_q;
  logic       next_pri_q;
  logic       next_fast_q;
  logic       next_absent_q;
  logic       next_lowv_q;
  logic       sec_in;
  logic       sec_out;
  logic       pri_in;
  logic       pri_out;
  logic       plug_in;
  logic       plug_out;

  always_comb begin
    next_sec_q    = cond.sec_present;
    next_pri_q    = cond.pri_present;
    next_fast_q   = cond.fast_charge;
    next_absent_q = cond.cell_absent_status;
    next_lowv_q   = cond.cell_above_lowv;
    sec_in        = cond.sec_present & ~sec_q;
    sec_out       = ~cond.sec_present & sec_q;
    pri_in        = cond.pri_present & ~pri_q;
    pri_out       = ~cond.pri_present & pri_q;
    plug_in       = sec_in | pri_in;
    plug_out      = sec_out | pri_out;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sec_q    <= 1'b0;
      pri_q    <= 1'b0;
      fast_q   <= 1'b0;
      absent_q <= 1'b0;
      lowv_q   <= 1'b0;
    end else begin
      sec_q    <= next_sec_q;
      pri_q    <= next_pri_q;
      fast_q   <= next_fast_q;
      absent_q <= next_absent_q;
      lowv_q   <= next_lowv_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event detection, one set term per flag
  logic [7:0] ev_set;

  always_comb begin
    ev_set = 8'h00;
    ev_set[`CEF_BIT_SRC_FAIL] = cond.source_check_failed;               // [R6]
    ev_set[`CEF_BIT_SEC_IN]   = sec_in | sec_out;                        // [R7]
    ev_set[`CEF_BIT_PRI_IN]   = pri_in | pri_out;                        // [R8]
    ev_set[`CEF_BIT_LOWV]     = (cond.charging & (cond.cell_above_lowv != lowv_q))
                              | (cond.charge_start & cond.cell_above_lowv)
                              | (plug_out & cond.cell_above_lowv);      // [R9]
    ev_set[`CEF_BIT_DONE]     = cond.charge_done & termination_enable;  // [R10]
    ev_set[`CEF_BIT_PHASE]    = cond.charging & (cond.fast_charge != fast_q); // [R11]
    ev_set[`CEF_BIT_WEAK]     = plug_in & (cond.cell_level < cell_min_threshold); // [R12]
    ev_set[`CEF_BIT_CELL]     = cond.cell_absent_status != absent_q;    // [R13]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-clear event flags
  logic [7:0] event_flags;
  logic [7:0] next_event_flags;

  always_comb begin
    next_event_flags = event_flags;
    if (event_read) begin
      next_event_flags = 8'h00;                                          // [R14]
    end
    // A set in the read cycle wins over the read clear; only a watchdog trip in that cycle drops it
    next_event_flags = next_event_flags | ev_set;                        // [R5] [R14]
    if (wd_trip) begin
      next_event_flags = `CEF_EVENT_RESET;                              // [R2]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      event_flags <= `CEF_EVENT_RESET;
    end else begin
      event_flags <= next_event_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host settings: watchdog run enable and minimum cell threshold
  logic       next_run_en;
  logic [2:0] next_vbmin;

  always_comb begin
    next_run_en = watchdog_run_enable;
    next_vbmin  = cell_min_threshold;
    if (run_en_write) begin
      next_run_en = req.wdata[`CEF_RUN_EN_BIT];
    end
    if (vbmin_write) begin
      next_vbmin = req.wdata[2:0];
    end
    // Expiry returns host settings to defaults, which also stops the watchdog
    if (wd_trip) begin
      next_run_en = 1'b0;                                               // [R2]
      next_vbmin  = 3'h0;                                               // [R2]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      watchdog_run_enable <= 1'b0;
      cell_min_threshold  <= 3'h0;
    end else begin
      watchdog_run_enable <= next_run_en;
      cell_min_threshold  <= next_vbmin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer expiry status
  logic [7:0] timer_status;
  logic [7:0] next_timer_status;

  always_comb begin
    next_timer_status = timer_status;
    // Either clear source wipes both bits; the timers are re-armed together
    if (run_en_set || plug_in) begin
      next_timer_status[`CEF_BIT_WATCHDOG] = 1'b0;                      // [R3]
      next_timer_status[`CEF_BIT_SAFETY]   = 1'b0;
    end
    if (cond.safety_timeout) begin
      next_timer_status[`CEF_BIT_SAFETY] = 1'b1;                        // [R4]
    end
    if (wd_trip) begin
      // Expiry resets everything else; the expired bit survives so software can see why
      next_timer_status = `CEF_TIMER_RESET;
      next_timer_status[`CEF_BIT_WATCHDOG] = 1'b1;                      // [R1]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timer_status <= `CEF_TIMER_RESET;
    end else begin
      timer_status <= next_timer_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read data
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = rdata;
    // Data holds between reads so a slow host can fetch it late
    if (req.rd) begin
      unique case (req.addr)
        `CEF_EVENT_ADDR:  next_rdata = event_flags;                     // [R5]
        `CEF_TIMER_ADDR:  next_rdata = timer_status;
        `CEF_RUN_EN_ADDR: next_rdata = {1'b0, watchdog_run_enable, 6'h00};
        `CEF_VBMIN_ADDR:  next_rdata = {5'h00, cell_min_threshold};
        default:          next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Default restore pulse for the rest of the chip
  logic       next_regs_to_default;

  always_comb begin
    next_regs_to_default = wd_trip;                                     // [R2]
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      regs_to_default <= 1'b0;
    end else begin
      regs_to_default <= next_regs_to_default;
    end
  end

endmodule // cef_flags

`default_nettype wire

// >>> bench/cef_flags_checker.sv
/* Port assertions for cef_flags. Assumes the bind below and single-cycle timer pulses. */
`timescale 1ns/1ns
`default_nettype none
module cef_flags_checker (
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire cef_pkg::cef_cond_t cond,
  input wire cef_pkg::cef_req_t  req,
  input wire logic [7:0]         rdata,
  input wire logic               watchdog_run_enable,
  input wire logic [2:0]         cell_min_threshold,
  input wire logic               regs_to_default
);
  import cef_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic trip = cond.watchdog_timeout & cond.charging;
  wire logic rd04 = req.rd & (req.addr == 8'h04) & ~trip;
  wire logic rd02 = req.rd & (req.addr == 8'h02) & ~trip;
  AST_TRIP_PULSE: assert property (trip |=> regs_to_default)
    else $error("no default pulse");
  AST_PULSE_CAUSE: assert property ($rose(regs_to_default) |-> $past(trip))
    else $error("stray default pulse");
  AST_TRIP_CLEAR: assert property (trip |=> !watchdog_run_enable && cell_min_threshold == 3'h0)
    else $error("trip left settings");
  // Reinsertion or a run-enable write in the gap would legally clear the bit
  AST_WD_STATUS: assert property (trip ##1 !req.wr && !$rose(cond.pri_present) && !$rose(cond.sec_present) ##1 rd02 |=> rdata[1])
    else $error("watchdog bit missing");
  AST_RUN_EN_CLEARS: assert property (req.wr && req.addr == 8'h19 && req.wdata[6] && !trip ##1 !trip ##1 rd02 |=> !rdata[1])
    else $error("watchdog bit kept");
  AST_FAIL_FLAG: assert property (cond.source_check_failed && !trip ##1 !trip && !req.rd ##1 rd04 |=> rdata[7])
    else $error("fail flag lost");
  AST_UNMAPPED: assert property (req.rd && !(req.addr inside {8'h02, 8'h04, 8'h0C, 8'h19}) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (!req.rd |=> $stable(rdata))
    else $error("read data moved");
  C_TRIP: cover property (trip);
  C_FLAG: cover property (rd04 ##1 rdata != 8'h00);
  C_RUN_EN: cover property (req.wr && req.addr == 8'h19);
  C_RACE: cover property (rd04 && cond.source_check_failed);
endmodule // cef_flags_checker
bind cef_flags cef_flags_checker i_chk (.sys_clk, .reset, .cond, .req, .rdata, .watchdog_run_enable,
  .cell_min_threshold, .regs_to_default);
`default_nettype wire

// >>> bench/cef_host.sv
/* Host register access model. Assumes rdata is valid one cycle after the rd edge. */
`timescale 1ns/1ns
`default_nettype none
module cef_host (
  input  wire logic             sys_clk,
  input  wire logic [7:0]       rdata,
  output var cef_pkg::cef_req_t req
);
  import cef_pkg::*;
  initial req = '0;
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk) req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge sys_clk) req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk) req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge sys_clk) req.wr <= 1'b0;
  endtask
endmodule // cef_host
`default_nettype wire

// >>> bench/cef_flags_bench.sv
/* Self-checking bench for cef_flags. Assumes cef_host drives the register port. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, v) begin samples_checked++; if ((v) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", n, e, v); end end
module cef_flags_bench;
  import cef_pkg::*;
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic       termination_enable = 1'b0;
  cef_cond_t  cond = '0;
  cef_req_t   req;
  logic [7:0] rdata;
  logic [7:0] d;
  int         num_errors = 0;
  int         samples_checked = 0;
  always #5 sys_clk = ~sys_clk;
  cef_flags i_dut (.sys_clk(sys_clk), .reset(reset), .cond(cond), .req(req), .termination_enable(termination_enable),
    .rdata(rdata), .watchdog_run_enable(), .cell_min_threshold(), .regs_to_default());
  cef_host i_host (.sys_clk(sys_clk), .rdata(rdata), .req(req));
  // Masks follow the packed field order of cef_cond_t
  task automatic flip(input cef_cond_t m);
    @(posedge sys_clk) cond <= cond ^ m;
  endtask
  task automatic pulse(input cef_cond_t m);
    flip(m);
    flip(m);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    `CHK($sformatf("reg %h", a), e, d)
  endtask
  task automatic finish_test;
    $display("Checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rchk(8'h04, 8'h00);
    pulse(14'h2000);
    rchk(8'h04, 8'h80);
    rchk(8'h04, 8'h00);
    // Event sampled on the same edge as the read: it must survive the clear
    fork
      i_host.rd(8'h04, d);
      pulse(14'h2000);
    join
    `CHK("race read", 8'h00, d)
    rchk(8'h04, 8'h80);
    flip(14'h0800);
    rchk(8'h04, 8'h20);
    i_host.wr(8'h0C, 8'h03);
    flip(14'h0008);
    flip(14'h1000);
    rchk(8'h04, 8'h42);
    flip(14'h0500);
    pulse(14'h0200);
    flip(14'h0040);
    pulse(14'h0080);
    rchk(8'h04, 8'h14);
    @(posedge sys_clk) termination_enable <= 1'b1;
    pulse(14'h0080);
    rchk(8'h04, 8'h08);
    flip(14'h0004);
    rchk(8'h04, 8'h01);
    pulse(14'h0001);
    rchk(8'h02, 8'h01);
    i_host.wr(8'h19, 8'h40);
    rchk(8'h02, 8'h00);
    rchk(8'h19, 8'h40);
    pulse(14'h2000);
    pulse(14'h0002);
    rchk(8'h02, 8'h02);
    rchk(8'h04, 8'h00);
    rchk(8'h19, 8'h00);
    rchk(8'h0C, 8'h00);
    rchk(8'h33, 8'h00);
    flip(14'h0800);
    flip(14'h0800);
    rchk(8'h02, 8'h00);
    finish_test();
  end
  // Whole sequence needs about 70 cycles
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule // cef_flags_bench
`default_nettype wire
